// file: shared/app_state_defs.vh
// Summary of operation
// - free run cycles from local timer
// - free run period optionally programmable
// - buffer event mode starts cycle on event
// - align to output event, input-only uses input
// - frame period written, checked against supported range
// - distributed clock mode starts on sync pulse
// - sync pulses from reference time plus delay
// - pre-op: object mailbox on, process data off
// - safe-op: transmit process data enabled
// - operational: receive process data also enabled
// - bootstrap: file transfer downloads accepted
// - upward changes step by step only
// - downward changes may skip states
// - bootstrap only from and to init
// - failed change stops, error reported
// - mailbox uses device addressing, both ways
// - process data logically addressed via map units
// - objects 0x1C00 to 0x1C4F are comm objects
// - object requests answered with confirmation in pre-op, safe-op and operational only
// - process data unacknowledged, one to eight bytes
`ifndef APP_STATE_DEFS_VH
`define APP_STATE_DEFS_VH
// ==============================
// register offsets
`define OFS_CTRL         8'h00
`define OFS_STATUS       8'h04
`define OFS_ERROR        8'h08
`define OFS_FREE_PERIOD  8'h0C
`define OFS_FRAME_PERIOD 8'h10
`define OFS_PROP_DELAY   8'h14
`define OFS_SYNC_CYCLE   8'h18
`define OFS_SYNC_SHIFT   8'h1C
`define OFS_CYCLE_COUNT  8'h20
`define OFS_OBJ_INDEX    8'h24
// ==============================
// fields
`define CTRL_MODE_LO     0
`define CTRL_MODE_HI     1
`define CTRL_IN_ONLY     2
`define CTRL_SYNC_EN     3
`define ERROR_ACK        0
// ==============================
// reset values
`define RST_FREE_PERIOD  32'h0000C350
`define RST_SYNC_CYCLE   32'h000F4240
// ==============================
// application states
`define ST_INIT          4'h1
`define ST_PREOP         4'h2
`define ST_BOOT          4'h3
`define ST_SAFEOP        4'h4
`define ST_OP            4'h8
// ==============================
// synchronisation modes
`define MODE_FREE        2'h0
`define MODE_BUF         2'h1
`define MODE_DC          2'h2
// ==============================
// object and process data limits
`define COMM_OBJ_LO      16'h1C00
`define COMM_OBJ_HI      16'h1C4F
`define PDO_LEN_MIN      4'h1
`define PDO_LEN_MAX      4'h8
`endif

// file: logic/slave_app_state_machine.v
`timescale 1ns/1ps
`include "app_state_defs.vh"
module slave_app_state_machine #(
	parameter MAILBOX_SUPPORTED = 1,
	parameter FREE_PERIOD_PROG  = 1,
	parameter FRAME_PERIOD_MIN  = 32'h000000C8,
	parameter FRAME_PERIOD_MAX  = 32'h00989680
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire        state_req_valid,
	input  wire [3:0]  state_req,
	input  wire        error_ack,
	input  wire        frame_period_wr,
	input  wire [31:0] frame_period_in,
	input  wire        buf_out_evt,
	input  wire        buf_in_evt,
	input  wire [31:0] ref_time,
	input  wire        mbx_valid,
	input  wire        mbx_device_addr,
	input  wire        mbx_write,
	input  wire        mbx_foe,
	input  wire        pdo_valid,
	input  wire        pdo_logical_addr,
	input  wire        pdo_rx,
	input  wire [3:0]  pdo_len,
	output reg  [3:0]  app_state,
	output reg         app_error,
	output reg         mbx_cfg_en,
	output reg         sdo_en,
	output reg         tx_pdo_en,
	output reg         rx_pdo_en,
	output reg         foe_en,
	output reg         cycle_start,
	output reg         sync_pulse_a,
	output reg         sync_pulse_b,
	output reg         mbx_accept,
	output reg         sdo_confirm,
	output reg         sdo_upload,
	output reg         foe_accept,
	output reg         pdo_apply,
	output reg         pdo_send
);
	// ==============================
	// helpers
	function time_reached;
		input [31:0] now;
		input [31:0] target;
		reg   [31:0] diff;
		begin
			diff = now - target;
			time_reached = ~diff[31];
		end
	endfunction

	function change_legal;
		input [3:0] cur;
		input [3:0] req;
		begin
			change_legal = 1'b0;
			if (req == cur)
				change_legal = 1'b1;
			else if (cur == `ST_BOOT)
				change_legal = (req == `ST_INIT);
			else if (req == `ST_BOOT)
				change_legal = (cur == `ST_INIT);
			else if (req == `ST_INIT)
				change_legal = 1'b1;
			else if (req == `ST_PREOP)
				change_legal = (cur != `ST_INIT) ||
					1'b1;
			else if (req == `ST_SAFEOP)
				change_legal = (cur == `ST_PREOP) ||
					(cur == `ST_OP);
			else if (req == `ST_OP)
				change_legal = (cur == `ST_SAFEOP);
		end
	endfunction

	function state_known;
		input [3:0] s;
		begin
			state_known = (s == `ST_INIT) || (s == `ST_PREOP) ||
				(s == `ST_BOOT) || (s == `ST_SAFEOP) ||
				(s == `ST_OP);
		end
	endfunction

	// ==============================
	// bus slave
	reg        wr_pend;
	reg  [7:0] wr_addr;
	reg  [3:0] ctrl;
	reg  [3:0] err_req;
	reg [31:0] free_period;
	reg [31:0] frame_period;
	reg [31:0] prop_delay;
	reg [31:0] sync_cycle;
	reg [31:0] sync_shift;
	reg [31:0] cycle_count;
	reg [15:0] obj_index;
	reg [31:0] next_rdata;
	wire       addr_phase;
	wire       wr_strobe;
	wire       period_ok;
	wire       obj_is_comm;
	wire [1:0] sync_mode;

	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign addr_phase = hsel & hready & htrans[1];
	assign wr_strobe  = wr_pend;
	assign sync_mode  = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
	assign period_ok  = (frame_period >= FRAME_PERIOD_MIN) &&
		(frame_period <= FRAME_PERIOD_MAX);
	assign obj_is_comm = (obj_index >= `COMM_OBJ_LO) &&
		(obj_index <= `COMM_OBJ_HI);

	always @* begin
		next_rdata = 32'h00000000;
		case (haddr[7:0])
		`OFS_CTRL:         next_rdata = {28'h0000000, ctrl};
		`OFS_STATUS:       next_rdata = {21'h000000, obj_is_comm,
			period_ok, foe_en, rx_pdo_en, tx_pdo_en, sdo_en,
			app_error, app_state};
		`OFS_ERROR:        next_rdata = {28'h0000000, err_req};
		`OFS_FREE_PERIOD:  next_rdata = free_period;
		`OFS_FRAME_PERIOD: next_rdata = frame_period;
		`OFS_PROP_DELAY:   next_rdata = prop_delay;
		`OFS_SYNC_CYCLE:   next_rdata = sync_cycle;
		`OFS_SYNC_SHIFT:   next_rdata = sync_shift;
		`OFS_CYCLE_COUNT:  next_rdata = cycle_count;
		`OFS_OBJ_INDEX:    next_rdata = {16'h0000, obj_index};
		default:           next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata  <= 32'h00000000;
		end else begin
			wr_pend <= addr_phase & hwrite;
			if (addr_phase)
				wr_addr <= haddr[7:0];
			if (addr_phase & ~hwrite)
				hrdata <= next_rdata;
		end
	end

	wire sw_err_ack;
	assign sw_err_ack = wr_strobe && (wr_addr == `OFS_ERROR) &&
		hwdata[`ERROR_ACK];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl        <= 4'h0;
			free_period <= `RST_FREE_PERIOD;
			prop_delay  <= 32'h00000000;
			sync_cycle  <= `RST_SYNC_CYCLE;
			sync_shift  <= 32'h00000000;
			obj_index   <= 16'h0000;
		end else if (wr_strobe) begin
			case (wr_addr)
			`OFS_CTRL:        ctrl <= hwdata[3:0];
			`OFS_FREE_PERIOD:
				if (FREE_PERIOD_PROG != 0)
					free_period <= hwdata;
			`OFS_PROP_DELAY:  prop_delay <= hwdata;
			`OFS_SYNC_CYCLE:  sync_cycle <= hwdata;
			`OFS_SYNC_SHIFT:  sync_shift <= hwdata;
			`OFS_OBJ_INDEX:   obj_index <= hwdata[15:0];
			default:          obj_index <= obj_index;
			endcase
		end
	end

	// master writes the frame period through the link
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			frame_period <= 32'h00000000;
		else if (frame_period_wr)
			frame_period <= frame_period_in;
	end

	// ==============================
	// application state machine
	reg        legal;
	always @* begin
		legal = state_known(state_req) &&
			change_legal(app_state, state_req);
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			app_state <= `ST_INIT;
			app_error <= 1'b0;
			err_req   <= 4'h0;
		end else begin
			if (state_req_valid && legal && !app_error)
				app_state <= state_req;
			if (state_req_valid && !legal) begin
				app_error <= 1'b1;
				err_req   <= state_req;
			end else if (error_ack || sw_err_ack)
				app_error <= 1'b0;
			if (state_req_valid && legal && app_error &&
				(state_req == `ST_INIT))
				app_state <= `ST_INIT;
		end
	end

	// state dependent services
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mbx_cfg_en <= 1'b0;
			sdo_en     <= 1'b0;
			tx_pdo_en  <= 1'b0;
			rx_pdo_en  <= 1'b0;
			foe_en     <= 1'b0;
		end else begin
			mbx_cfg_en <= (MAILBOX_SUPPORTED != 0) &&
				(app_state == `ST_INIT);
			sdo_en     <= (MAILBOX_SUPPORTED != 0) &&
				((app_state == `ST_PREOP) ||
				(app_state == `ST_SAFEOP) ||
				(app_state == `ST_OP));
			tx_pdo_en  <= (app_state == `ST_SAFEOP) ||
				(app_state == `ST_OP);
			rx_pdo_en  <= (app_state == `ST_OP);
			foe_en     <= (app_state == `ST_BOOT);
		end
	end

	// ==============================
	// mailbox and process data gating
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mbx_accept  <= 1'b0;
			sdo_confirm <= 1'b0;
			sdo_upload  <= 1'b0;
			foe_accept  <= 1'b0;
			pdo_apply   <= 1'b0;
			pdo_send    <= 1'b0;
		end else begin
			mbx_accept  <= mbx_valid && mbx_device_addr &&
				(sdo_en || foe_en);
			sdo_confirm <= mbx_valid && mbx_device_addr &&
				!mbx_foe && sdo_en;
			if (mbx_valid && mbx_device_addr && !mbx_foe && sdo_en)
				sdo_upload <= !mbx_write;
			foe_accept  <= mbx_valid && mbx_device_addr && mbx_foe &&
				mbx_write && foe_en;
			pdo_apply   <= pdo_valid && pdo_logical_addr && pdo_rx &&
				rx_pdo_en && (pdo_len >= `PDO_LEN_MIN) &&
				(pdo_len <= `PDO_LEN_MAX);
			pdo_send    <= pdo_valid && pdo_logical_addr && !pdo_rx &&
				tx_pdo_en && (pdo_len >= `PDO_LEN_MIN) &&
				(pdo_len <= `PDO_LEN_MAX);
		end
	end

	// ==============================
	// distributed clock sync pulses
	reg  [31:0] next_a;
	reg  [31:0] next_b;
	wire [31:0] corr_time;
	wire        sync_en;
	assign corr_time = ref_time + prop_delay;
	assign sync_en   = ctrl[`CTRL_SYNC_EN];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			next_a       <= 32'h00000000;
			next_b       <= 32'h00000000;
			sync_pulse_a <= 1'b0;
			sync_pulse_b <= 1'b0;
		end else if (!sync_en) begin
			next_a       <= corr_time + sync_cycle;
			next_b       <= corr_time + sync_cycle + sync_shift;
			sync_pulse_a <= 1'b0;
			sync_pulse_b <= 1'b0;
		end else begin
			sync_pulse_a <= time_reached(corr_time, next_a);
			sync_pulse_b <= time_reached(corr_time, next_b);
			if (time_reached(corr_time, next_a))
				next_a <= next_a + sync_cycle;
			if (time_reached(corr_time, next_b))
				next_b <= next_b + sync_cycle;
		end
	end

	// ==============================
	// local cycle generation
	reg  [31:0] free_cnt;
	reg         next_cycle;
	wire        free_tick;
	assign free_tick = (free_cnt >= free_period - 32'h00000001);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			free_cnt <= 32'h00000000;
		else if (sync_mode != `MODE_FREE || free_tick)
			free_cnt <= 32'h00000000;
		else
			free_cnt <= free_cnt + 32'h00000001;
	end

	always @* begin
		case (sync_mode)
		`MODE_FREE: next_cycle = free_tick;
		`MODE_BUF:  next_cycle = ctrl[`CTRL_IN_ONLY] ?
			buf_in_evt : buf_out_evt;
		`MODE_DC:   next_cycle = sync_pulse_a;
		default:    next_cycle = 1'b0;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cycle_start <= 1'b0;
			cycle_count <= 32'h00000000;
		end else begin
			cycle_start <= next_cycle;
			if (next_cycle)
				cycle_count <= cycle_count + 32'h00000001;
		end
	end

endmodule // slave_app_state_machine

// file: testbench/app_state_asserts.sv
`timescale 1ns/1ps
`include "app_state_defs.vh"
module app_state_chk (
	input logic       hclk, hresetn, state_req_valid, app_error,
	input logic       sdo_en, tx_pdo_en, rx_pdo_en, foe_en,
	input logic       mbx_valid, mbx_device_addr, mbx_foe, mbx_accept,
	input logic       sdo_confirm, pdo_valid, pdo_logical_addr,
	input logic       pdo_apply, pdo_send,
	input logic [3:0] state_req, app_state, pdo_len
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ==============================
	// state changes
	skip_refused_a: assert property (state_req_valid && !app_error &&
		app_state == `ST_INIT && state_req[3:2] != 2'h0
		|=> app_state == `ST_INIT && app_error) else $error("skip honoured");
	to_init_a: assert property (state_req_valid && state_req == `ST_INIT
		|=> app_state == `ST_INIT) else $error("init request lost");
	boot_entry_a: assert property ($changed(app_state) &&
		app_state == `ST_BOOT |-> $past(app_state) == `ST_INIT)
		else $error("bad boot entry");
	boot_exit_a: assert property ($changed(app_state) &&
		$past(app_state) == `ST_BOOT |-> app_state == `ST_INIT)
		else $error("bad boot exit");
	refuse_hold_a: assert property (state_req_valid && app_error &&
		state_req != `ST_INIT |=> $stable(app_state))
		else $error("state moved under error");
	// ==============================
	// enables and answers
	preop_en_a: assert property (app_state == `ST_PREOP
		|=> sdo_en && !tx_pdo_en && !rx_pdo_en) else $error("preop enables");
	safeop_en_a: assert property (app_state == `ST_SAFEOP
		|=> tx_pdo_en && !rx_pdo_en) else $error("safeop enables");
	op_en_a: assert property (app_state == `ST_OP
		|=> tx_pdo_en && rx_pdo_en) else $error("op enables");
	boot_en_a: assert property (app_state == `ST_BOOT
		|=> foe_en && !tx_pdo_en) else $error("boot enables");
	sdo_answer_a: assert property (mbx_valid && mbx_device_addr &&
		!mbx_foe && sdo_en |=> sdo_confirm) else $error("no confirm");
	mbx_addr_a: assert property (mbx_valid && !mbx_device_addr
		|=> !mbx_accept) else $error("mailbox misaddressed");
	pdo_bad_a: assert property (pdo_valid && (!pdo_logical_addr ||
		pdo_len == 4'h0 || pdo_len > 4'h8) |=> !pdo_apply && !pdo_send)
		else $error("bad pdo used");
	cover property (app_state == `ST_OP);
	cover property (app_state == `ST_BOOT);
	cover property (pdo_apply);
endmodule // app_state_chk
bind slave_app_state_machine app_state_chk u_chk (.*);

// file: testbench/fieldbus_master.sv
`timescale 1ns/1ps
module fieldbus_master (
	input  logic        hclk,
	output logic        state_req_valid, error_ack, frame_period_wr,
	output logic        buf_out_evt, buf_in_evt, mbx_valid, pdo_valid,
	output logic        mbx_device_addr, mbx_write, mbx_foe,
	output logic        pdo_logical_addr, pdo_rx,
	output logic [3:0]  state_req, pdo_len,
	output logic [31:0] frame_period_in, ref_time
);
	// ==============================
	// valids drop and payloads are inverted after each request so stale values never look valid
	initial begin
		{state_req_valid, error_ack, frame_period_wr, buf_out_evt} = '0;
		{buf_in_evt, mbx_valid, pdo_valid, ref_time} = '0;
		{mbx_device_addr, mbx_write, mbx_foe, pdo_logical_addr} = '0;
		{pdo_rx, state_req, pdo_len, frame_period_in} = '0;
	end
	always @(posedge hclk) ref_time <= ref_time + 32'h1;
	task req(input [3:0] s);
		@(posedge hclk);
		state_req_valid <= 1'b1;
		state_req <= s;
		@(posedge hclk);
		state_req_valid <= 1'b0;
		state_req <= ~s;
	endtask
	task pulse(input int k);
		@(posedge hclk);
		{error_ack, buf_out_evt, buf_in_evt} <= 3'h1 << k;
		@(posedge hclk);
		{error_ack, buf_out_evt, buf_in_evt} <= 3'h0;
	endtask
	task period(input [31:0] p);
		@(posedge hclk);
		frame_period_wr <= 1'b1;
		frame_period_in <= p;
		@(posedge hclk);
		frame_period_wr <= 1'b0;
		frame_period_in <= ~p;
	endtask
	task mbx(input d, w, f);
		@(posedge hclk);
		mbx_valid <= 1'b1;
		{mbx_device_addr, mbx_write, mbx_foe} <= {d, w, f};
		@(posedge hclk);
		mbx_valid <= 1'b0;
		{mbx_device_addr, mbx_write, mbx_foe} <= ~{d, w, f};
	endtask
	task pdo(input l, r, input [3:0] n);
		@(posedge hclk);
		pdo_valid <= 1'b1;
		{pdo_logical_addr, pdo_rx, pdo_len} <= {l, r, n};
		@(posedge hclk);
		pdo_valid <= 1'b0;
		{pdo_logical_addr, pdo_rx, pdo_len} <= ~{l, r, n};
	endtask
endmodule // fieldbus_master

// file: testbench/tb_fieldbus_slave_app_state_sync.sv
`timescale 1ns/1ps
`include "app_state_defs.vh"
module tb_fieldbus_slave_app_state_sync;
	logic        hclk, hresetn, hsel, hwrite;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, rdata;
	wire         hreadyout, hresp;
	wire         hready = hreadyout;
	wire  [31:0] hrdata, frame_period_in, ref_time;
	wire  [3:0]  app_state, state_req, pdo_len;
	wire         state_req_valid, error_ack, frame_period_wr, buf_out_evt;
	wire         buf_in_evt, mbx_valid, mbx_device_addr, mbx_write, mbx_foe;
	wire         pdo_valid, pdo_logical_addr, pdo_rx, app_error, mbx_cfg_en;
	wire         sdo_en, tx_pdo_en, rx_pdo_en, foe_en, cycle_start;
	wire         sync_pulse_a, sync_pulse_b, mbx_accept, sdo_confirm;
	wire         sdo_upload, foe_accept, pdo_apply, pdo_send;
	int          error_cnt = 0, num_checks = 0, tests = 0;
	int          starts = 0, pulses = 0, s0, p0;
	slave_app_state_machine uut (.*);
	fieldbus_master u_master (.*);
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		starts += cycle_start;
		pulses += sync_pulse_a;
	end
	// ==============================
	// helpers
	task conclude;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task check(input [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tend;
		tests++;
		$display("test %0d done", tests);
	endtask
	task w;
		for (int i = 0; i < 50; i++) begin
			@(posedge hclk);
			if (hready === 1'b1) return;
		end
		error_cnt++;
		conclude;
	endtask
	task ahb(input wr, input [7:0] a, input [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		w;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		w;
		rdata = hrdata;
	endtask
	task rd(input [7:0] a, input [31:0] m, e);
		ahb(1'b0, a, '0);
		check(rdata & m, e);
	endtask
	task go(input [3:0] s, st, input e, input [3:0] en);
		u_master.req(s);
		#1 check({app_error, app_state}, {e, st});
		@(posedge hclk);
		#1 check({foe_en, rx_pdo_en, tx_pdo_en, sdo_en}, en);
	endtask
	task mb(input d, wr, f, input [2:0] e);
		u_master.mbx(d, wr, f);
		#1 check({mbx_accept, sdo_confirm, foe_accept}, e);
	endtask
	task pd(input l, r, input [3:0] n, input [1:0] e);
		u_master.pdo(l, r, n);
		#1 check({pdo_apply, pdo_send}, e);
	endtask
	// ==============================
	// main sequence
	initial begin
		{hresetn, hsel, hwrite, htrans} = '0;
		hsize = 3'h2;
		{haddr, hwdata} = '0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		check(hresp, 0);
		ahb(1'b1, `OFS_FREE_PERIOD, 32'hA);
		rd(`OFS_FREE_PERIOD, '1, 32'hA);
		rd(`OFS_STATUS, 32'h1FF, 32'h1);
		rd(8'h40, '1, '0);
		check({mbx_cfg_en, sdo_en, tx_pdo_en}, 3'h4);
		repeat (20) @(posedge hclk);
		#1 s0 = starts;
		repeat (40) @(posedge hclk);
		#1 check(starts - s0, 4);
		tend;
		go(`ST_SAFEOP, `ST_INIT, 1'b1, 4'h0);
		rd(`OFS_ERROR, 32'hF, `ST_SAFEOP);
		go(`ST_PREOP, `ST_INIT, 1'b1, 4'h0);
		u_master.pulse(2);
		#1 check(app_error, 0);
		tend;
		go(`ST_PREOP, `ST_PREOP, 1'b0, 4'h1);
		mb(1'b1, 1'b0, 1'b0, 3'h6);
		check(sdo_upload, 1);
		mb(1'b1, 1'b1, 1'b0, 3'h6);
		check(sdo_upload, 0);
		mb(1'b1, 1'b1, 1'b1, 3'h4);
		u_master.mbx(1'b0, 1'b1, 1'b0);
		#1 check(mbx_accept, 0);
		pd(1'b1, 1'b1, 4'h4, 2'h0);
		go(`ST_SAFEOP, `ST_SAFEOP, 1'b0, 4'h3);
		pd(1'b1, 1'b1, 4'h8, 2'h0);
		pd(1'b1, 1'b0, 4'h8, 2'h1);
		go(`ST_OP, `ST_OP, 1'b0, 4'h7);
		pd(1'b1, 1'b1, 4'h8, 2'h2);
		pd(1'b1, 1'b1, 4'h9, 2'h0);
		pd(1'b1, 1'b0, 4'h0, 2'h0);
		pd(1'b0, 1'b1, 4'h1, 2'h0);
		go(`ST_INIT, `ST_INIT, 1'b0, 4'h0);
		tend;
		go(`ST_BOOT, `ST_BOOT, 1'b0, 4'h8);
		mb(1'b1, 1'b1, 1'b1, 3'h5);
		go(`ST_PREOP, `ST_BOOT, 1'b1, 4'h8);
		u_master.pulse(2);
		go(`ST_INIT, `ST_INIT, 1'b0, 4'h0);
		tend;
		ahb(1'b1, `OFS_CTRL, 32'h1);
		#1 s0 = starts;
		u_master.pulse(1);
		u_master.pulse(0);
		repeat (2) @(posedge hclk);
		#1 check(starts - s0, 1);
		ahb(1'b1, `OFS_CTRL, 32'h5);
		#1 s0 = starts;
		u_master.pulse(0);
		u_master.pulse(1);
		repeat (2) @(posedge hclk);
		#1 check(starts - s0, 1);
		tend;
		ahb(1'b1, `OFS_SYNC_CYCLE, 32'h14);
		ahb(1'b1, `OFS_CTRL, 32'hA);
		#1 s0 = starts;
		p0 = pulses;
		repeat (100) @(posedge hclk);
		ahb(1'b1, `OFS_CTRL, 32'h2);
		repeat (3) @(posedge hclk);
		#1 check(pulses - p0 > 3, 1);
		check(starts - s0, pulses - p0);
		tend;
		u_master.period(32'h64);
		rd(`OFS_STATUS, 32'h200, '0);
		u_master.period(32'h3E8);
		rd(`OFS_STATUS, 32'h200, 32'h200);
		rd(`OFS_FRAME_PERIOD, '1, 32'h3E8);
		ahb(1'b1, `OFS_OBJ_INDEX, 32'h1C4F);
		rd(`OFS_STATUS, 32'h400, 32'h400);
		ahb(1'b1, `OFS_OBJ_INDEX, 32'h1C50);
		rd(`OFS_STATUS, 32'h400, '0);
		tend;
		conclude;
	end
endmodule // tb_fieldbus_slave_app_state_sync
